// file: design/key_matrix_scanner.sv
// key_matrix_scanner: key matrix readout with software strobe, hardware segment scan and mixed use
// assumes key levels arrive already digitised in ninths of the selected reference, synchronous to aclk
//
// Implementation choices: the register offsets and the AXI4-Lite interface to the registers.
`timescale 1ns/10ps
module key_matrix_scanner #(
  parameter int unsigned INPUTS = 4,
  parameter int unsigned LINES = 4,
  parameter int unsigned LINE_CYC = key_scan_pkg::LINE_CAPTURE_CYC,
  parameter int unsigned LOW_CYC = key_scan_pkg::RETURN_LOW_CYC
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [31:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [31:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [INPUTS*3-1:0] key_level,
  output logic [LINES-1:0] segment_return_low,
  output logic [LINES-1:0] port1_out,
  output logic [LINES-1:0] port1_oe,
  output logic [INPUTS-1:0] input_pullup_select,
  output logic [INPUTS-1:0] input_float_select,
  output logic [2:0] threshold_select,
  output logic reference_select,
  output logic wake_up
);
  import key_scan_pkg::*;

  localparam int unsigned LW = $clog2(LINES);
  localparam int unsigned CW = $clog2(LINE_CYC + 1);

  logic [31:0] ctrl_q, format_q, port1_q;
  logic [LW-1:0] ptr_q, line_q;
  logic [CW-1:0] cyc_q;
  logic [INPUTS-1:0] scan_data_q [LINES];
  logic [INPUTS-1:0] above;
  logic aw_hold_q, w_hold_q;
  logic [7:0] awaddr_q;
  logic [31:0] wdata_q;
  logic [3:0] wstrb_q;
  logic do_write, do_read;
  logic wait_q, wake_q;

  // byte-lane merge used by the control, format and port1 registers
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] st);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (st[b]) r[b*8 +: 8] = nw[b*8 +: 8];
    end
    return r;
  endfunction : merge

  // decode of one input's format pair
  function automatic input_format_t fmt_of(input logic [31:0] f, input int unsigned k);
    return input_format_t'({f[FLOAT_LSB + k], f[PULLUP_LSB + k]});
  endfunction : fmt_of

  wire hw_scan_on = ctrl_q[HW_SCAN_BIT];
  wire [2:0] thr = ctrl_q[THR_LSB +: 3];

  key_compare #(.INPUTS(INPUTS)) u_cmp (
    .aclk(aclk),
    .aresetn(aresetn),
    .threshold_select(thr),
    .key_level(key_level),
    .above_q(above)
  );

  // write address and data may arrive in either order; each is held until both are present
  assign do_write = aw_hold_q && w_hold_q && !s_axi_bvalid;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_hold_q <= 1'b0;
      w_hold_q <= 1'b0;
      awaddr_q <= 8'h00;
      wdata_q <= 32'h0000_0000;
      wstrb_q <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
    end else begin
      s_axi_awready <= !aw_hold_q && !s_axi_awready && s_axi_awvalid;
      s_axi_wready <= !w_hold_q && !s_axi_wready && s_axi_wvalid;
      if (s_axi_awvalid && s_axi_awready) begin
        aw_hold_q <= 1'b1;
        awaddr_q <= s_axi_awaddr[7:0];
      end else if (do_write) begin
        aw_hold_q <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_hold_q <= 1'b1;
        wdata_q <= s_axi_wdata;
        wstrb_q <= s_axi_wstrb;
      end else if (do_write) begin
        w_hold_q <= 1'b0;
      end
    end
  end

  // write response, unmapped or read-only addresses answer slverr
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= AXI_OKAY;
    end else if (do_write) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= (awaddr_q == CTRL_OFS || awaddr_q == FORMAT_OFS || awaddr_q == PORT1_OFS ||
                      awaddr_q == CONTROL_PORT_OFS) ? AXI_OKAY : AXI_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end
  // every mode and format bit is its own flop
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_q <= CTRL_RST;
      format_q <= FORMAT_RST;
      port1_q <= PORT1_RST;
    end else begin
      if (do_write && awaddr_q == CTRL_OFS) ctrl_q <= merge(ctrl_q, wdata_q, wstrb_q);
      if (do_write && awaddr_q == FORMAT_OFS) format_q <= merge(format_q, wdata_q, wstrb_q);
      if (do_write && awaddr_q == PORT1_OFS) port1_q <= merge(port1_q, wdata_q, wstrb_q);
    end
  end

  // one read at a time; the data is captured one cycle after arready
  assign do_read = s_axi_arvalid && s_axi_arready;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
    end else begin
      s_axi_arready <= !s_axi_arready && !s_axi_rvalid && s_axi_arvalid;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= AXI_OKAY;
    end else if (do_read) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= AXI_OKAY;
      unique case (s_axi_araddr[7:0])
        CTRL_OFS: s_axi_rdata <= ctrl_q;
        FORMAT_OFS: s_axi_rdata <= format_q;
        PORT1_OFS: s_axi_rdata <= port1_q;
        // key input port reads the live comparison
        // port-strobed keys through key input port
        KEY_IN_OFS: s_axi_rdata <= {{(32-INPUTS){1'b0}}, above};
        // segment keys through scan data port
        SCAN_DATA_OFS: s_axi_rdata <= {{(32-INPUTS){1'b0}}, scan_data_q[ptr_q]};
        // monitor shows the line under capture
        STATUS_OFS: s_axi_rdata <= {23'h0, wake_q, {(4-LW){1'b0}}, ptr_q, {(4-LW){1'b0}}, line_q};
        CONTROL_PORT_OFS: s_axi_rdata <= {{(32-LW){1'b0}}, ptr_q};
        default: begin
          s_axi_rdata <= 32'h0000_0000;
          s_axi_rresp <= AXI_SLVERR;
        end
      endcase
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // pointer steps on scan data or control port read; a control port write loads the written value plus one
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ptr_q <= '0;
    end else if (do_write && awaddr_q == CONTROL_PORT_OFS) begin
      ptr_q <= wdata_q[LW-1:0] + LW'(1);
    end else if (do_read && (s_axi_araddr[7:0] == SCAN_DATA_OFS || s_axi_araddr[7:0] == CONTROL_PORT_OFS)) begin
      ptr_q <= ptr_q + LW'(1);
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn || !hw_scan_on) begin
      cyc_q <= '0;
      line_q <= '0;
    end else if (cyc_q == CW'(LINE_CYC - 1)) begin
      cyc_q <= '0;
      line_q <= (line_q == LW'(LINES - 1)) ? '0 : line_q + LW'(1);
    end else begin
      cyc_q <= cyc_q + CW'(1);
    end
  end

  // latch compare at end of the low window
  // pressed key or jumper latches one
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      for (int l = 0; l < LINES; l++) scan_data_q[l] <= '0;
    end else if (hw_scan_on && cyc_q == CW'(LOW_CYC - 1)) begin
      // a press pulls the input below threshold, so a low compare means pressed
      for (int k = 0; k < INPUTS; k++) begin
        if (fmt_of(format_q, k) != FMT_PULL_DOWN) scan_data_q[line_q][k] <= !above[k];
      end
    end
  end

  // decoder holds selected return low 80 us
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      segment_return_low <= '0;
    end else begin
      for (int l = 0; l < LINES; l++) begin
        segment_return_low[l] <= hw_scan_on && line_q == LW'(l) && cyc_q < CW'(LOW_CYC);
      end
    end
  end

  // port1 strobes driven where direction output, whatever the return enable field
  // line levels come from port1 data
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      port1_out <= '0;
      port1_oe <= '0;
    end else begin
      port1_out <= port1_q[P1_DATA_LSB +: LINES];
      port1_oe <= port1_q[P1_DIR_LSB +: LINES];
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      input_pullup_select <= '0;
      input_float_select <= '0;
      threshold_select <= '0;
      reference_select <= 1'b0;
    end else begin
      input_pullup_select <= format_q[PULLUP_LSB +: INPUTS];
      input_float_select <= format_q[FLOAT_LSB +: INPUTS];
      threshold_select <= thr;
      reference_select <= ctrl_q[REF_SEL_BIT];
    end
  end

  // wake_up raised by a high on a pull-down input while waiting; the wait bit stays set
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wait_q <= 1'b0;
      wake_q <= 1'b0;
      wake_up <= 1'b0;
    end else begin
      wait_q <= ctrl_q[WAIT_BIT];
      wake_up <= 1'b0;
      for (int k = 0; k < INPUTS; k++) begin
        // a level of 0.6 supply is code 5 or more in ninths
        if (wait_q && fmt_of(format_q, k) == FMT_PULL_DOWN && key_level[k*3 +: 3] >= 3'h5) begin
          wake_up <= 1'b1;
        end
      end
      if (wake_up) wake_q <= 1'b1;
      else if (do_read && s_axi_araddr[7:0] == STATUS_OFS) wake_q <= 1'b0;
    end
  end
endmodule : key_matrix_scanner

// file: design/key_scan_pkg.sv
// key_scan_pkg: register map, field layout, reset values and timing for the key matrix scanner
// assumes a 50 MHz aclk and a 32-bit axi4-lite register port
package key_scan_pkg;
  localparam int unsigned CLK_HZ = 50000000;
  // register byte offsets
  localparam logic [7:0] CTRL_OFS = 8'h00;
  localparam logic [7:0] FORMAT_OFS = 8'h04;
  localparam logic [7:0] PORT1_OFS = 8'h08;
  localparam logic [7:0] KEY_IN_OFS = 8'h0C;
  localparam logic [7:0] SCAN_DATA_OFS = 8'h10;
  localparam logic [7:0] STATUS_OFS = 8'h14;
  localparam logic [7:0] CONTROL_PORT_OFS = 8'h18;
  // control register fields
  localparam int unsigned THR_LSB = 0;
  localparam int unsigned REF_SEL_BIT = 3;
  localparam int unsigned HW_SCAN_BIT = 4;
  localparam int unsigned RET_EN_LSB = 8;
  localparam int unsigned WAIT_BIT = 12;
  // format register fields
  localparam int unsigned PULLUP_LSB = 0;
  localparam int unsigned FLOAT_LSB = 4;
  // port1 register fields
  localparam int unsigned P1_DATA_LSB = 0;
  localparam int unsigned P1_DIR_LSB = 4;
  // status register fields
  localparam int unsigned MON_LSB = 0;
  localparam int unsigned PTR_LSB = 4;
  localparam int unsigned WAKE_BIT = 8;
  // reset values
  localparam logic [31:0] CTRL_RST = 32'h0000_0000;
  localparam logic [31:0] FORMAT_RST = 32'h0000_0000;
  localparam logic [31:0] PORT1_RST = 32'h0000_0000;
  // timing: one return line is held low 80 us, a full line capture takes 2 ms
  localparam int unsigned RETURN_LOW_US = 80;
  localparam int unsigned LINE_CAPTURE_US = 2000;
  localparam int unsigned RETURN_LOW_CYC = RETURN_LOW_US * (CLK_HZ / 1000000);
  localparam int unsigned LINE_CAPTURE_CYC = LINE_CAPTURE_US * (CLK_HZ / 1000000);
  // input formats
  typedef enum logic [1:0] {
    FMT_PULL_DOWN = 2'b00,
    FMT_REF_PULLUP = 2'b01,
    FMT_SUPPLY_PULLUP = 2'b10,
    FMT_FLOAT = 2'b11
  } input_format_t;
  localparam logic [1:0] AXI_OKAY = 2'b00;
  localparam logic [1:0] AXI_SLVERR = 2'b10;
endpackage : key_scan_pkg

// file: design/key_compare.sv
// key_compare: one registered comparator per key input against threshold_select
// assumes key_level carries each input's sampled level as a 3-bit ninths code
`timescale 1ns/10ps
module key_compare #(
  parameter int unsigned INPUTS = 4
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [2:0] threshold_select,
  input wire logic [INPUTS*3-1:0] key_level,
  output logic [INPUTS-1:0] above_q
);
  import key_scan_pkg::*;
  genvar i;
  generate
    for (i = 0; i < INPUTS; i++) begin : g_cmp
      always_ff @(posedge aclk) begin
        if (!aresetn) begin
          above_q[i] <= 1'b0;
        end else begin
          above_q[i] <= key_level[i*3 +: 3] > threshold_select;
        end
      end
    end
  endgenerate
endmodule : key_compare

// file: verification/key_matrix_model.sv
// key_matrix_model: switch matrix with diodes, four lines by four inputs
// assumes the scanner's outputs are steady between clock edges
`timescale 1ns/10ps
module key_matrix_model (
  input wire logic [15:0] key_pressed,
  input wire logic [3:0] segment_return_low,
  input wire logic [3:0] port1_out,
  input wire logic [3:0] port1_oe,
  input wire logic [3:0] input_pullup_select,
  input wire logic [3:0] input_float_select,
  output logic [11:0] key_level
);
  logic [3:0] col;
  // strobe or grounded return
  // pulled-down inputs only see a driven high port line; others sit at code 7, seven ninths of the reference
  always_comb begin
    key_level = '0;
    col = '0;
    for (int i = 0; i < 4; i++) begin
      for (int j = 0; j < 4; j++) col[j] = key_pressed[j*4+i];
      if (!input_pullup_select[i] && !input_float_select[i])
        key_level[i*3 +: 3] = |(col & port1_out & port1_oe) ? 3'h7 : 3'h0;
      else
        key_level[i*3 +: 3] = |(col & segment_return_low) ? 3'h1 : 3'h7;
    end
  end
endmodule : key_matrix_model

// file: verification/key_scan_sva.sv
// key_scan_sva: port-level checks of the key matrix scanner
// assumes only the top module's ports; attached by bind below
`timescale 1ns/10ps
module key_scan_sva #(
  parameter int unsigned INPUTS = 4,
  parameter int unsigned LINES = 4,
  parameter int unsigned LINE_CYC = 20,
  parameter int unsigned LOW_CYC = 4
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [INPUTS*3-1:0] key_level,
  input wire logic [LINES-1:0] segment_return_low,
  input wire logic [INPUTS-1:0] input_pullup_select,
  input wire logic [INPUTS-1:0] input_float_select,
  input wire logic [2:0] threshold_select,
  input wire logic wake_up
);
  logic [LINES-1:0] prev_q, last_q;
  logic [31:0] low_cnt_q, gap_q;
  logic seen_q, pd_hi;
  wire rise = |(segment_return_low & ~prev_q);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // any pulled-down input at or above the wake level
  always_comb begin
    pd_hi = 1'b0;
    for (int i = 0; i < INPUTS; i++)
      if (!input_pullup_select[i] && !input_float_select[i] && key_level[i*3 +: 3] >= 3'h5) pd_hi = 1'b1;
  end
  // length of the current low window
  always_ff @(posedge aclk) begin
    prev_q <= aresetn ? segment_return_low : '0;
    low_cnt_q <= (aresetn && |segment_return_low) ? low_cnt_q + 32'h1 : '0;
  end
  // spacing and order of return line starts; the first start has no predecessor
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      seen_q <= 1'b0;
      gap_q <= '0;
      last_q <= '0;
    end else if (rise) begin
      seen_q <= 1'b1;
      gap_q <= 32'h1;
      last_q <= segment_return_low;
    end else begin
      gap_q <= gap_q + 32'h1;
    end
  end
  one_return_a: assert property ($onehot0(segment_return_low)) else $error("two return lines low");
  low_window_a: assert property (prev_q != 0 && segment_return_low == 0 |-> low_cnt_q == LOW_CYC)
    else $error("return low window length wrong");
  line_period_a: assert property (rise && seen_q |-> gap_q == LINE_CYC) else $error("line period wrong");
  line_order_a: assert property (rise && seen_q |-> segment_return_low == {last_q[LINES-2:0], last_q[LINES-1]})
    else $error("return line order wrong");
  wake_source_a: assert property (wake_up |-> $past(pd_hi)) else $error("wake without pulled-down high");
  wake_thr_a: assert property (wake_up |-> $stable(threshold_select)) else $error("wake moved threshold");
  bresp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");
  rdata_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped");
  read_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid) else $error("read answer late");
endmodule : key_scan_sva

bind key_matrix_scanner key_scan_sva #(.INPUTS(INPUTS), .LINES(LINES), .LINE_CYC(LINE_CYC), .LOW_CYC(LOW_CYC)) u_sva (
  .aclk(aclk), .aresetn(aresetn), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
  .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
  .s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
  .key_level(key_level), .segment_return_low(segment_return_low), .input_pullup_select(input_pullup_select),
  .input_float_select(input_float_select), .threshold_select(threshold_select), .wake_up(wake_up));

// file: verification/tb.sv
// tb: key matrix scanner with a switch matrix model, driven over axi4-lite
// assumes short scan counts: 20-cycle lines, 4-cycle low windows
`timescale 1ns/10ps
module tb;
  import key_scan_pkg::*;
  logic aclk = 0, aresetn = 0;
  logic [31:0] awaddr = 0, wdata = 0, araddr = 0, rdata;
  logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic awready, wready, bvalid, arready, rvalid, wake_up, ref_sel;
  logic [1:0] bresp, rresp;
  logic [3:0] seg, p1o, p1e, pu, fl;
  logic [2:0] thr;
  logic [11:0] lvl;
  logic [15:0] keys = 0;
  logic [33:0] rq[$];
  logic [1:0] bq[$];
  int bad_count = 0, compares = 0, wake_cnt = 0, n;
  key_matrix_scanner #(.LINE_CYC(20), .LOW_CYC(4)) u_dut (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .key_level(lvl), .segment_return_low(seg), .port1_out(p1o), .port1_oe(p1e),
    .input_pullup_select(pu), .input_float_select(fl), .threshold_select(thr), .reference_select(ref_sel),
    .wake_up(wake_up));
  key_matrix_model u_keys (.key_pressed(keys), .segment_return_low(seg), .port1_out(p1o), .port1_oe(p1e),
    .input_pullup_select(pu), .input_float_select(fl), .key_level(lvl));
  initial forever #10 aclk = ~aclk;
  task automatic chk(input string nm, input logic [33:0] s, input logic [33:0] e);
    compares++;
    if (s !== e) begin
      bad_count++;
      $display("[FAIL] %s expected %h seen %h", nm, e, s);
    end
  endtask : chk
  task automatic test_done();
    $display("compares %0d bad_count %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : test_done
  // address and data offered together, each dropped once taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
    bq.push_back(r);
    @(posedge aclk);
    awaddr <= {24'h0, a};
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (awready === 1'b1) awvalid <= 1'b0;
      if (wready === 1'b1) wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    bready <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
    rq.push_back({r, d});
    @(posedge aclk);
    araddr <= {24'h0, a};
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (arready === 1'b1) arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    rready <= 1'b0;
  endtask : rd
  // answers are matched against the oldest note
  always @(posedge aclk) begin
    if (rvalid === 1'b1 && rready) chk("read", {rresp, rdata}, rq.pop_front());
    if (bvalid === 1'b1 && bready) chk("bresp", {32'h0, bresp}, {32'h0, bq.pop_front()});
    if (wake_up === 1'b1) wake_cnt++;
  end
  initial begin
    #400000;
    bad_count++;
    test_done();
  end
  initial begin
    void'($urandom(33));
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    rd(CTRL_OFS, CTRL_RST, AXI_OKAY);
    rd(FORMAT_OFS, FORMAT_RST, AXI_OKAY);
    rd(PORT1_OFS, PORT1_RST, AXI_OKAY);
    rd(8'h1C, 32'h0, AXI_SLVERR);
    wr(KEY_IN_OFS, 32'h1, AXI_SLVERR);
    // software strobe of each port1 line, threshold 4/9
    keys <= 16'($urandom);
    wr(CTRL_OFS, 32'h0000_0F04, AXI_OKAY);
    wr(FORMAT_OFS, 32'h0, AXI_OKAY);
    for (int j = 0; j < 4; j++) begin
      wr(PORT1_OFS, 32'hF0 | (32'h1 << j), AXI_OKAY);
      rd(KEY_IN_OFS, {28'h0, keys[j*4 +: 4]}, AXI_OKAY);
    end
    // wait mode: pulled-down high wakes, pulled-up high must not
    keys <= 16'h0001;
    wr(PORT1_OFS, 32'hF1, AXI_OKAY);
    n = wake_cnt;
    wr(CTRL_OFS, 32'h0000_1F04, AXI_OKAY);
    repeat (5) @(posedge aclk);
    chk("wake", {33'h0, wake_cnt > n}, 34'h1);
    chk("thr", {31'h0, thr}, {31'h0, 3'h4});
    wr(FORMAT_OFS, 32'hF, AXI_OKAY);
    repeat (2) @(posedge aclk);
    n = wake_cnt;
    repeat (5) @(posedge aclk);
    chk("no wake", {33'h0, wake_cnt > n}, 34'h0);
    // hardware segment scan with 6/9 threshold, read twice to show retention
    keys <= 16'($urandom);
    wr(CTRL_OFS, 32'h0000_001E, AXI_OKAY);
    // pin flops settle one edge after the register write lands
    @(posedge aclk);
    chk("pins", {22'h0, pu, fl, thr, ref_sel}, {22'h0, 4'hF, 4'h0, 3'h6, 1'b1});
    repeat (200) @(posedge aclk);
    wr(CONTROL_PORT_OFS, 32'h3, AXI_OKAY);
    for (int k = 0; k < 8; k++) rd(SCAN_DATA_OFS, {28'h0, keys[(k%4)*4 +: 4]}, AXI_OKAY);
    // mixed: inputs 0-1 pulled up on segments, 2-3 pulled down on port1 strobes
    // no key on the pulled-up inputs, so those bits read high whatever line is captured
    keys <= 16'($urandom) & 16'hCCCC;
    wr(FORMAT_OFS, 32'h3, AXI_OKAY);
    wr(CTRL_OFS, 32'h0000_0F1E, AXI_OKAY);
    for (int j = 0; j < 4; j++) begin
      wr(PORT1_OFS, 32'hF0 | (32'h1 << j), AXI_OKAY);
      rd(KEY_IN_OFS, {28'h0, keys[j*4+2 +: 2], 2'b11}, AXI_OKAY);
    end
    test_done();
  end
endmodule : tb
